// ### inc/dwa_if.sv
// link between the debug register block and its debugger/system controller
`timescale 1ns/1ps
`default_nettype none
interface dwa_if;
	logic        req;       // register access request, held until ack
	logic        wr;        // 1 write, 0 read
	logic [2:0]  idx;       // register index
	logic [31:0] wdata;     // write data
	logic [31:0] rdata;     // read data, valid with ack
	logic        ack;       // one-cycle completion
	logic        inv_en;    // invasive_debug_enable_in
	logic        ninv_en;   // noninvasive_debug_enable_in
	logic        por_n;     // system_poweron_reset_n
	logic        warm_rst;  // warm reset of the processor
	logic        rst_req;   // debug_reset_request_out
	logic        no_pd;     // no_power_down_out

	modport dev (input req, wr, idx, wdata, inv_en, ninv_en, por_n, warm_rst,
		output rdata, ack, rst_req, no_pd);
	modport host (output req, wr, idx, wdata, inv_en, ninv_en, por_n, warm_rst,
		input rdata, ack, rst_req, no_pd);
endinterface : dwa_if
`default_nettype wire

// ### inc/dwa_params.svh
// constants shared by both ends of the debug watch/auth/power-down link
// ============================================================
// How it works
// [R1] byte-lane select narrows word watch to bytes
// [R2] access qualifier: 01 load, 10 store, 11 either
// [R3] swaps hit any; exclusives follow load/store
// [R4] privilege qualifier: 01 priv, 10 user, 11 all
// [R5] compare access privilege, not processor mode
// [R6] enable bit zero resets watchpoint inactive
// [R7] control bit 13 reads zero, writers preserve
// [R8] lock status reads all zero, read-only
// [R9] auth bits 7 and 5 read one
// [R10] auth bit 6 is invasive OR non-invasive enable
// [R11] auth bit 4 is invasive enable level
// [R12] auth bits 3 to 0 read zero
// [R13] hold bit keeps core in reset after warm reset
// [R14] power-on reset clears hold bit
// [R15] writing force bit pulses reset request four cycles
// [R16] no-power-down bit drives no-power-down output
// [R17] power-down bits 31 to 3 read zero, preserved
// [R18] power controller skips power-off when no-power-down high
// [R19] reset controller may reset core on request pulse
// [R20] request pulse timed from one-cycle write strobe
`ifndef DWA_PARAMS_SVH
`define DWA_PARAMS_SVH

// ============================================================
// device register indices on the link
`define DWA_IDX_WP_CTRL   3'h0
`define DWA_IDX_WP_VALUE  3'h1
`define DWA_IDX_LOCK      3'h2
`define DWA_IDX_AUTH      3'h3
`define DWA_IDX_PWR       3'h4

// ============================================================
// watchpoint control fields
`define DWA_WC_RSVD_BIT   13
`define DWA_WC_BAS_HI     12
`define DWA_WC_BAS_LO     5
`define DWA_WC_LS_HI      4
`define DWA_WC_LS_LO      3
`define DWA_WC_PRIV_HI    2
`define DWA_WC_PRIV_LO    1
`define DWA_WC_EN_BIT     0
`define DWA_WC_RESET      13'h0000

// ============================================================
// authentication status fields
`define DWA_AU_NI_IMPL    7
`define DWA_AU_NI_EN      6
`define DWA_AU_I_IMPL     5
`define DWA_AU_I_EN       4
`define DWA_AU_NS_VAL     4'h0

// ============================================================
// power-down/reset control fields
`define DWA_PR_HOLD_BIT   2
`define DWA_PR_FORCE_BIT  1
`define DWA_PR_NOPD_BIT   0
`define DWA_PR_RESET      2'h0
`define DWA_RST_PULSE_CYC 4

// ============================================================
// controller APB map (byte addresses)
`define DWA_APB_CMD       12'h000
`define DWA_APB_WDATA     12'h004
`define DWA_APB_RDATA     12'h008
`define DWA_APB_STATUS    12'h00C
`define DWA_APB_PINS      12'h010
`define DWA_CMD_GO_BIT    0
`define DWA_CMD_WR_BIT    1
`define DWA_CMD_IDX_LO    2
`define DWA_ST_BUSY_BIT   0
`define DWA_ST_DONE_BIT   1
`define DWA_ST_NOPD_BIT   2
`define DWA_ST_RREQ_BIT   3
`define DWA_ST_RSEEN_BIT  4
`define DWA_PINS_RESET    6'h04

`endif

// ### inc/dwa_pkg.sv
// types shared by both ends of the debug watch/auth/power-down link
package dwa_pkg;

	typedef enum logic [1:0] {
		DWA_LS_RSVD  = 2'h0,
		DWA_LS_LOAD  = 2'h1,
		DWA_LS_STORE = 2'h2,
		DWA_LS_ANY   = 2'h3
	} dwa_ls_t;

	typedef enum logic [1:0] {
		DWA_PV_RSVD = 2'h0,
		DWA_PV_PRIV = 2'h1,
		DWA_PV_USER = 2'h2,
		DWA_PV_ANY  = 2'h3
	} dwa_priv_t;

	typedef enum logic [0:0] {
		DWA_HS_IDLE = 1'h0,
		DWA_HS_WAIT = 1'h1
	} dwa_hst_t;

endpackage : dwa_pkg

// ### logic/dwa_device.sv
// debug register block: watchpoint, lock, authentication and power-down control
`timescale 1ns/1ps
`default_nettype none
`include "dwa_params.svh"
module dwa_device #(
	parameter int RST_PULSE = `DWA_RST_PULSE_CYC    // reset request length
) (
	input  wire logic        clk_i,          // 100 MHz processor clock
	input  wire logic        srst_i,         // synchronous reset, high
	dwa_if.dev               lnk,            // debugger side
	input  wire logic        acc_valid_i,    // memory access this cycle
	input  wire logic [31:0] acc_addr_i,     // access address
	input  wire logic [3:0]  acc_be_i,       // byte lanes of the word
	input  wire logic        acc_load_i,     // load, load exclusive or swap
	input  wire logic        acc_store_i,    // store, store exclusive or swap
	input  wire logic        acc_priv_i,     // access carries privileged attribute
	output logic             wp_hit_o,       // watchpoint hit pulse
	output logic             core_reset_o    // non-debug logic held in reset
);

	// ============================================================
	// state
	logic [12:0] wc_ff;
	logic [12:0] nxt_wc;
	logic [31:0] wv_ff;
	logic [31:0] nxt_wv;
	logic [1:0]  pr_ff;
	logic [1:0]  nxt_pr;
	logic        hold_ff;
	logic        nxt_hold;
	logic [2:0]  pulse_ff;
	logic [2:0]  nxt_pulse;
	logic        ack_ff;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic        hit_ff;
	logic        nxt_hit;

	// ============================================================
	// link decode
	wire         take    = lnk.req & ~ack_ff;
	wire         wr_take = take & lnk.wr;
	wire         rd_take = take & ~lnk.wr;
	wire         por     = srst_i | ~lnk.por_n;
	wire         sel_wc  = (lnk.idx == `DWA_IDX_WP_CTRL);
	wire         sel_wv  = (lnk.idx == `DWA_IDX_WP_VALUE);
	wire         sel_pr  = (lnk.idx == `DWA_IDX_PWR);
	// one-cycle strobe, the force bit itself is never stored
	wire         force_stb = wr_take & sel_pr & lnk.wdata[`DWA_PR_FORCE_BIT]; // see [R20]

	// ============================================================
	// register writes
	always_comb begin
		nxt_wc = wc_ff;
		nxt_wv = wv_ff;
		nxt_pr = pr_ff;
		if (wr_take && sel_wc) begin
			nxt_wc = lnk.wdata[12:0]; // see [R1] see [R2] see [R4] see [R6]
		end
		if (wr_take && sel_wv) begin
			nxt_wv = {lnk.wdata[31:2], 2'h0}; // see [R1]
		end
		if (wr_take && sel_pr) begin
			nxt_pr = {lnk.wdata[`DWA_PR_HOLD_BIT], lnk.wdata[`DWA_PR_NOPD_BIT]}; // see [R17]
		end
	end

	// ============================================================
	// read mux, authentication bits sampled live at the read
	function automatic logic [31:0] read_word(input logic [2:0] idx);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (idx == `DWA_IDX_WP_CTRL) begin
			w[12:0] = wc_ff; // see [R7]
		end else if (idx == `DWA_IDX_WP_VALUE) begin
			w = wv_ff;
		end else if (idx == `DWA_IDX_LOCK) begin
			w = 32'h0000_0000; // see [R8]
		end else if (idx == `DWA_IDX_AUTH) begin
			w[`DWA_AU_NI_IMPL] = 1'b1; // see [R9]
			w[`DWA_AU_I_IMPL]  = 1'b1; // see [R9]
			w[`DWA_AU_NI_EN]   = lnk.inv_en | lnk.ninv_en; // see [R10]
			w[`DWA_AU_I_EN]    = lnk.inv_en; // see [R11]
			w[3:0]             = `DWA_AU_NS_VAL; // see [R12]
		end else if (idx == `DWA_IDX_PWR) begin
			w[`DWA_PR_HOLD_BIT] = pr_ff[1]; // see [R17]
			w[`DWA_PR_NOPD_BIT] = pr_ff[0];
		end
		return w;
	endfunction : read_word

	assign nxt_rdata = rd_take ? read_word(lnk.idx) : rdata_ff;

	// ============================================================
	// reset request pulse and hold-in-reset
	always_comb begin
		nxt_pulse = pulse_ff;
		if (force_stb) begin
			nxt_pulse = 3'(RST_PULSE); // see [R15]
		end else if (pulse_ff != 3'h0) begin
			nxt_pulse = pulse_ff - 3'h1; // see [R20]
		end
	end

	// hold latches on a warm reset while the hold bit is set
	always_comb begin
		nxt_hold = hold_ff;
		if (!pr_ff[1]) begin
			nxt_hold = 1'b0; // see [R13]
		end else if (lnk.warm_rst) begin
			nxt_hold = 1'b1; // see [R13]
		end
	end

	// ============================================================
	// watchpoint match
	wire dwa_pkg::dwa_ls_t   ls_q   = dwa_pkg::dwa_ls_t'(wc_ff[`DWA_WC_LS_HI:`DWA_WC_LS_LO]);
	wire dwa_pkg::dwa_priv_t priv_q = dwa_pkg::dwa_priv_t'(wc_ff[`DWA_WC_PRIV_HI:`DWA_WC_PRIV_LO]);
	wire [7:0] lanes    = acc_addr_i[2] ? {acc_be_i, 4'h0} : {4'h0, acc_be_i};
	wire       addr_ok  = (acc_addr_i[31:3] == wv_ff[31:3]);
	wire       lane_ok  = |(lanes & wc_ff[`DWA_WC_BAS_HI:`DWA_WC_BAS_LO]); // see [R1]
	// swaps assert both load and store; exclusive stores hit whatever the outcome
	wire       ls_ok    = ((ls_q == dwa_pkg::DWA_LS_LOAD)  & acc_load_i)                // see [R2]
	                    | ((ls_q == dwa_pkg::DWA_LS_STORE) & acc_store_i)               // see [R3]
	                    | ((ls_q == dwa_pkg::DWA_LS_ANY)   & (acc_load_i | acc_store_i)); // see [R3]
	// the access's own privilege attribute, not the processor mode
	wire       priv_ok  = ((priv_q == dwa_pkg::DWA_PV_PRIV) & acc_priv_i)  // see [R4] see [R5]
	                    | ((priv_q == dwa_pkg::DWA_PV_USER) & ~acc_priv_i) // see [R4] see [R5]
	                    | (priv_q == dwa_pkg::DWA_PV_ANY);                 // see [R4]

	assign nxt_hit = acc_valid_i & wc_ff[`DWA_WC_EN_BIT] & addr_ok & lane_ok & ls_ok & priv_ok; // see [R6]

	// ============================================================
	// flops
	always_ff @(posedge clk_i) begin
		if (por) begin
			wc_ff   <= `DWA_WC_RESET; // see [R6]
			wv_ff   <= 32'h0000_0000;
			pr_ff   <= `DWA_PR_RESET; // see [R14] see [R16]
			hold_ff <= 1'b0; // see [R14]
		end else begin
			wc_ff   <= nxt_wc;
			wv_ff   <= nxt_wv;
			pr_ff   <= nxt_pr;
			hold_ff <= nxt_hold;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pulse_ff <= 3'h0;
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			hit_ff   <= 1'b0;
		end else begin
			pulse_ff <= nxt_pulse;
			ack_ff   <= take;
			rdata_ff <= nxt_rdata;
			hit_ff   <= nxt_hit;
		end
	end

	// ============================================================
	// outputs
	assign lnk.ack      = ack_ff;
	assign lnk.rdata    = rdata_ff;
	assign lnk.rst_req  = (pulse_ff != 3'h0); // see [R15]
	assign lnk.no_pd    = pr_ff[0]; // see [R16]
	assign wp_hit_o     = hit_ff;
	assign core_reset_o = lnk.warm_rst | hold_ff; // see [R13]

endmodule : dwa_device
`default_nettype wire

// ### logic/dwa_host.sv
// debugger and system controller end: APB command registers driving the link
`timescale 1ns/1ps
`default_nettype none
`include "dwa_params.svh"
module dwa_host (
	input  wire logic        clk_i,           // 100 MHz clock
	input  wire logic        srst_i,          // synchronous reset, high
	input  wire logic        psel,            // APB select
	input  wire logic        penable,         // APB access phase
	input  wire logic        pwrite,          // APB direction
	input  wire logic [11:0] paddr,           // APB byte address
	input  wire logic [31:0] pwdata,          // APB write data
	output logic      [31:0] prdata,          // APB read data
	output logic             pready,          // APB ready
	output logic             pslverr,         // APB error on unmapped address
	output logic             core_power_off_o, // power actually removed
	dwa_if.host              lnk              // device side
);

	// ============================================================
	// state
	dwa_pkg::dwa_hst_t st_ff;
	dwa_pkg::dwa_hst_t nxt_st;
	logic        wr_ff;
	logic [2:0]  idx_ff;
	logic [31:0] wdata_ff;
	logic [31:0] rdata_ff;
	logic        done_ff;
	logic        nxt_done;
	logic        rseen_ff;
	logic        nxt_rseen;
	logic [5:0]  pins_ff;

	// ============================================================
	// APB decode, zero wait states
	wire apb_wr  = psel & penable & pwrite;
	wire apb_rd  = psel & penable & ~pwrite;
	wire a_cmd   = (paddr == `DWA_APB_CMD);
	wire a_wdata = (paddr == `DWA_APB_WDATA);
	wire a_rdata = (paddr == `DWA_APB_RDATA);
	wire a_stat  = (paddr == `DWA_APB_STATUS);
	wire a_pins  = (paddr == `DWA_APB_PINS);
	wire mapped  = a_cmd | a_wdata | a_rdata | a_stat | a_pins;
	wire go      = apb_wr & a_cmd & pwdata[`DWA_CMD_GO_BIT] & (st_ff == dwa_pkg::DWA_HS_IDLE);

	// reserved fields read as zero, so clearing them preserves them
	function automatic logic [31:0] keep_rsvd(input logic [2:0] idx, input logic [31:0] d);
		logic [31:0] m;
		m = 32'hFFFF_FFFF;
		if (idx == `DWA_IDX_WP_CTRL) begin
			m[`DWA_WC_RSVD_BIT] = 1'b0; // see [R7]
		end else if (idx == `DWA_IDX_PWR) begin
			m = 32'h0000_0007; // see [R17]
		end
		return d & m;
	endfunction : keep_rsvd

	// ============================================================
	// link sequencer
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			dwa_pkg::DWA_HS_IDLE: begin
				if (go) begin
					nxt_st = dwa_pkg::DWA_HS_WAIT;
				end
			end
			dwa_pkg::DWA_HS_WAIT: begin
				if (lnk.ack) begin
					nxt_st = dwa_pkg::DWA_HS_IDLE;
				end
			end
			default: nxt_st = dwa_pkg::DWA_HS_IDLE;
		endcase
	end

	wire fin = (st_ff == dwa_pkg::DWA_HS_WAIT) & lnk.ack;
	wire clr = apb_wr & a_stat;
	// set wins over a same-cycle write-one clear
	assign nxt_done  = fin | (done_ff & ~(clr & pwdata[`DWA_ST_DONE_BIT]));
	assign nxt_rseen = lnk.rst_req | (rseen_ff & ~(clr & pwdata[`DWA_ST_RSEEN_BIT]));

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_ff    <= dwa_pkg::DWA_HS_IDLE;
			wr_ff    <= 1'b0;
			idx_ff   <= 3'h0;
			wdata_ff <= 32'h0000_0000;
			rdata_ff <= 32'h0000_0000;
			done_ff  <= 1'b0;
			rseen_ff <= 1'b0;
			pins_ff  <= `DWA_PINS_RESET;
		end else begin
			st_ff    <= nxt_st;
			done_ff  <= nxt_done;
			rseen_ff <= nxt_rseen;
			if (go) begin
				wr_ff  <= pwdata[`DWA_CMD_WR_BIT];
				idx_ff <= pwdata[`DWA_CMD_IDX_LO+2:`DWA_CMD_IDX_LO];
			end
			if (apb_wr && a_wdata) begin
				wdata_ff <= pwdata;
			end
			if (apb_wr && a_pins) begin
				pins_ff <= pwdata[5:0];
			end
			if (fin && !wr_ff) begin
				rdata_ff <= lnk.rdata;
			end
		end
	end

	// ============================================================
	// APB read
	always_comb begin
		prdata = 32'h0000_0000;
		if (apb_rd && a_cmd) begin
			prdata[`DWA_CMD_IDX_LO+2:`DWA_CMD_IDX_LO] = idx_ff;
			prdata[`DWA_CMD_WR_BIT] = wr_ff;
		end else if (apb_rd && a_wdata) begin
			prdata = wdata_ff;
		end else if (apb_rd && a_rdata) begin
			prdata = rdata_ff;
		end else if (apb_rd && a_stat) begin
			prdata[`DWA_ST_BUSY_BIT]  = (st_ff == dwa_pkg::DWA_HS_WAIT);
			prdata[`DWA_ST_DONE_BIT]  = done_ff;
			prdata[`DWA_ST_NOPD_BIT]  = lnk.no_pd;
			prdata[`DWA_ST_RREQ_BIT]  = lnk.rst_req;
			prdata[`DWA_ST_RSEEN_BIT] = rseen_ff;
		end else if (apb_rd && a_pins) begin
			prdata[5:0] = pins_ff;
		end
	end

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// ============================================================
	// link outputs and system controllers
	assign lnk.req     = (st_ff == dwa_pkg::DWA_HS_WAIT);
	assign lnk.wr      = wr_ff;
	assign lnk.idx     = idx_ff;
	assign lnk.wdata   = keep_rsvd(idx_ff, wdata_ff);
	assign lnk.inv_en  = pins_ff[0];
	assign lnk.ninv_en = pins_ff[1];
	assign lnk.por_n   = pins_ff[2];
	// optional auto reset on the device's request pulse
	assign lnk.warm_rst = pins_ff[3] | (pins_ff[4] & lnk.rst_req); // see [R19]
	// emulate mode: power stays on while no-power-down is high
	assign core_power_off_o = pins_ff[5] & ~lnk.no_pd; // see [R18]

endmodule : dwa_host
`default_nettype wire

// ### verification/dwa_monitor.sv
// link checker for the debug watch/auth/power-down register block
`timescale 1ns/1ps
`default_nettype none
`include "dwa_params.svh"
module dwa_monitor #(
	parameter int RST_PULSE = `DWA_RST_PULSE_CYC    // reset request length
) (
	input  wire logic        clk_i,    // clock
	input  wire logic        srst_i,   // sync reset, high
	input  wire logic        req,      // access request
	input  wire logic        wr,       // write
	input  wire logic [2:0]  idx,      // register index
	input  wire logic [31:0] wdata,    // write data
	input  wire logic [31:0] rdata,    // read data
	input  wire logic        ack,      // completion
	input  wire logic        inv_en,   // invasive enable
	input  wire logic        ninv_en,  // non-invasive enable
	input  wire logic        por_n,    // power-on reset, low
	input  wire logic        warm_rst, // warm reset
	input  wire logic        rst_req,  // reset request pulse
	input  wire logic        no_pd     // no-power-down level
);
	// ============================================================
	// pulse length counter
	logic [7:0] hi_cnt_ff;
	logic [7:0] nxt_hi_cnt;
	logic       rst_dly_ff;
	assign nxt_hi_cnt = rst_req ? hi_cnt_ff + 8'h01 : 8'h00;
	always_ff @(posedge clk_i) begin
		rst_dly_ff <= srst_i;
		if (srst_i) hi_cnt_ff <= 8'h00;
		else hi_cnt_ff <= nxt_hi_cnt;
	end
	// ============================================================
	// assertions
	default clocking @(posedge clk_i); endclocking
	// first edge after reset still sees pre-reset unknowns through $past
	default disable iff (srst_i || rst_dly_ff);
	chk_pulse_len: assert property ($fell(rst_req) |-> hi_cnt_ff == 8'(RST_PULSE))
		else $error("reset request pulse has wrong length");
	chk_pulse_max: assert property (rst_req |-> hi_cnt_ff < 8'(RST_PULSE))
		else $error("reset request pulse too long");
	chk_pulse_cause: assert property ($rose(rst_req) |-> $past(req && wr && idx == 3'h4 && wdata[1]))
		else $error("reset request without force write");
	chk_nopd_write: assert property ((ack && $past(req && wr && idx == 3'h4)) |-> no_pd == $past(wdata[0]))
		else $error("no-power-down does not follow written bit");
	chk_nopd_steady: assert property ($changed(no_pd) |-> $past(req && wr && idx == 3'h4) || $past(!por_n))
		else $error("no-power-down changed without cause");
	chk_nopd_por: assert property (!por_n |=> !no_pd)
		else $error("power-on reset left no-power-down set");
	chk_auth_read: assert property ((ack && $past(req && !wr && idx == 3'h3)) |->
		rdata == {24'h0, 1'h1, $past(inv_en | ninv_en), 1'h1, $past(inv_en), 4'h0})
		else $error("authentication status read wrong");
	chk_lock_read: assert property ((ack && $past(req && !wr && idx == 3'h2)) |-> rdata == 32'h0)
		else $error("lock status not zero");
	chk_pr_read: assert property ((ack && $past(req && !wr && idx == 3'h4)) |->
		rdata[31:3] == 29'h0 && !rdata[1] && rdata[0] == $past(no_pd))
		else $error("power-down control read wrong");
	chk_wc_upper: assert property ((ack && $past(req && !wr && idx == 3'h0)) |-> rdata[31:13] == 19'h0)
		else $error("watchpoint control upper bits not zero");
	chk_ack_timely: assert property ($rose(req) |=> ack)
		else $error("no acknowledge one cycle after request");
endmodule : dwa_monitor
`default_nettype wire

// ### verification/dwa_tb.sv
// self-checking bench: host and device joined over the link, driven by APB
`timescale 1ns/1ps
`default_nettype none
`include "dwa_params.svh"
module dwa_tb;
	localparam int RST_PULSE = `DWA_RST_PULSE_CYC;
	logic        clk_i;
	logic        srst_i;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        core_power_off_o;
	logic        acc_valid_i;
	logic [31:0] acc_addr_i;
	logic [3:0]  acc_be_i;
	logic        acc_load_i;
	logic        acc_store_i;
	logic        acc_priv_i;
	logic        wp_hit_o;
	logic        core_reset_o;
	logic [31:0] rd_val;
	logic        apb_err;
	int          err_total;
	int          comparisons;
	int          pulse_cnt;
	int          k;
	dwa_if lnk_if ();
	dwa_host dwa_host_inst (.clk_i(clk_i), .srst_i(srst_i), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .core_power_off_o(core_power_off_o), .lnk(lnk_if));
	dwa_device #(.RST_PULSE(RST_PULSE)) dwa_device_inst (.clk_i(clk_i), .srst_i(srst_i),
		.lnk(lnk_if), .acc_valid_i(acc_valid_i), .acc_addr_i(acc_addr_i), .acc_be_i(acc_be_i),
		.acc_load_i(acc_load_i), .acc_store_i(acc_store_i), .acc_priv_i(acc_priv_i),
		.wp_hit_o(wp_hit_o), .core_reset_o(core_reset_o));
	dwa_monitor #(.RST_PULSE(RST_PULSE)) dwa_monitor_inst (.clk_i(clk_i), .srst_i(srst_i),
		.req(lnk_if.req), .wr(lnk_if.wr), .idx(lnk_if.idx), .wdata(lnk_if.wdata),
		.rdata(lnk_if.rdata), .ack(lnk_if.ack), .inv_en(lnk_if.inv_en),
		.ninv_en(lnk_if.ninv_en), .por_n(lnk_if.por_n), .warm_rst(lnk_if.warm_rst),
		.rst_req(lnk_if.rst_req), .no_pd(lnk_if.no_pd));
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (lnk_if.rst_req === 1'h1) pulse_cnt = pulse_cnt + 1;
	end
	// ============================================================
	// access tasks
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'h1;
		@(posedge clk_i);
		while (pready !== 1'h1) @(posedge clk_i);
		q = prdata;
		apb_err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	// device access through the host command registers
	task dev(input logic w, input logic [2:0] ix, input logic [31:0] d);
		logic [31:0] st;
		int          n;
		n = 0;
		apb(1'h1, `DWA_APB_WDATA, d, st);
		apb(1'h1, `DWA_APB_CMD, {27'h0, ix, w, 1'h1}, st);
		st = 32'h0;
		while (st[`DWA_ST_DONE_BIT] !== 1'h1 && n < 40) begin
			apb(1'h0, `DWA_APB_STATUS, 32'h0, st);
			n++;
		end
		chk({31'h0, st[`DWA_ST_DONE_BIT]}, 32'h1, "access done");
		apb(1'h1, `DWA_APB_STATUS, 32'h0000_0002, st);
		apb(1'h0, `DWA_APB_RDATA, 32'h0, rd_val);
	endtask : dev
	task dchk(input logic [2:0] ix, input logic [31:0] exp, input string m);
		dev(1'h0, ix, 32'h0);
		chk(rd_val, exp, m);
	endtask : dchk
	task pins(input logic [5:0] v);
		apb(1'h1, `DWA_APB_PINS, {26'h0, v}, rd_val);
	endtask : pins
	task acc(input logic [31:0] a, input logic [3:0] be, input logic ld, st, pv, ex);
		@(posedge clk_i);
		acc_valid_i <= 1'h1;
		acc_addr_i <= a;
		acc_be_i <= be;
		acc_load_i <= ld;
		acc_store_i <= st;
		acc_priv_i <= pv;
		@(posedge clk_i);
		acc_valid_i <= 1'h0;
		@(negedge clk_i);
		chk({31'h0, wp_hit_o}, {31'h0, ex}, "watch hit");
	endtask : acc
	function logic [31:0] wc(input logic [7:0] bas, input logic [1:0] ls, pv, input logic en);
		return {19'h0, bas, ls, pv, en};
	endfunction : wc
	task close_out;
		$display("comparisons %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : close_out
	// ============================================================
	// tests
	initial begin
		clk_i = 1'h0;
		srst_i = 1'h1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{acc_valid_i, acc_addr_i, acc_be_i, acc_load_i, acc_store_i, acc_priv_i} = '0;
		err_total = 0;
		comparisons = 0;
		pulse_cnt = 0;
		repeat (2) @(posedge clk_i);
		srst_i <= 1'h0;
		dchk(3'h0, 32'h0, "control reset");
		dchk(3'h4, 32'h0, "power control reset");
		chk({31'h0, lnk_if.no_pd}, 32'h0, "no-power-down reset");
		apb(1'h0, 12'h014, 32'h0, rd_val);
		chk({31'h0, apb_err}, 32'h1, "unmapped address error");
		chk(rd_val, 32'h0, "unmapped address reads zero");
		dev(1'h1, 3'h2, 32'hFFFF_FFFF);
		dchk(3'h2, 32'h0, "lock status");
		dev(1'h1, 3'h3, 32'hFFFF_FFFF);
		for (k = 0; k < 4; k++) begin
			pins({4'h1, k[1:0]});
			dchk(3'h3, {24'h0, 1'h1, |k[1:0], 1'h1, k[0], 4'h0}, "auth");
		end
		dev(1'h1, 3'h0, 32'hFFFF_FFFF);
		dchk(3'h0, 32'h0000_1FFF, "control bit 13");
		pins(6'h24);
		dev(1'h1, 3'h4, 32'h1);
		chk({31'h0, lnk_if.no_pd}, 32'h1, "no-power-down set");
		chk({31'h0, core_power_off_o}, 32'h0, "power kept");
		dev(1'h1, 3'h4, 32'h0);
		chk({31'h0, lnk_if.no_pd}, 32'h0, "no-power-down clear");
		chk({31'h0, core_power_off_o}, 32'h1, "power removed");
		pins(6'h14);
		pulse_cnt = 0;
		dev(1'h1, 3'h4, 32'h2);
		chk(32'(pulse_cnt), 32'(RST_PULSE), "pulse length");
		dchk(3'h4, 32'h0, "force bit not stored");
		apb(1'h0, `DWA_APB_STATUS, 32'h0, rd_val);
		chk({31'h0, rd_val[`DWA_ST_RSEEN_BIT]}, 32'h1, "reset seen");
		chk({31'h0, apb_err}, 32'h0, "mapped address no error");
		pins(6'h04);
		dev(1'h1, 3'h4, 32'h4);
		dchk(3'h4, 32'h4, "hold bit");
		pins(6'h0C);
		pins(6'h04);
		@(negedge clk_i);
		chk({31'h0, core_reset_o}, 32'h1, "held in reset");
		dev(1'h1, 3'h4, 32'h0);
		@(negedge clk_i);
		chk({31'h0, core_reset_o}, 32'h0, "hold released");
		dev(1'h1, 3'h4, 32'h5);
		pins(6'h00);
		pins(6'h04);
		dchk(3'h4, 32'h0, "power-on clears");
		dev(1'h1, 3'h1, 32'h0000_1000);
		dev(1'h1, 3'h0, wc(8'h0F, 2'h3, 2'h3, 1'h1));
		acc(32'h0000_1000, 4'h1, 1'h1, 1'h0, 1'h1, 1'h1);
		acc(32'h0000_1004, 4'hF, 1'h1, 1'h0, 1'h1, 1'h0);
		acc(32'h0000_1008, 4'hF, 1'h1, 1'h0, 1'h1, 1'h0);
		dev(1'h1, 3'h0, wc(8'hF0, 2'h3, 2'h3, 1'h1));
		acc(32'h0000_1004, 4'h2, 1'h1, 1'h0, 1'h1, 1'h1);
		for (k = 0; k < 4; k++) begin
			dev(1'h1, 3'h0, wc(8'hFF, k[1:0], 2'h3, 1'h1));
			acc(32'h0000_1000, 4'hF, 1'h1, 1'h0, 1'h1, k[0]);
			acc(32'h0000_1000, 4'hF, 1'h0, 1'h1, 1'h1, k[1]);
			acc(32'h0000_1000, 4'hF, 1'h1, 1'h1, 1'h1, |k[1:0]);
			dev(1'h1, 3'h0, wc(8'hFF, 2'h3, k[1:0], 1'h1));
			acc(32'h0000_1000, 4'hF, 1'h1, 1'h0, 1'h1, k[0]);
			acc(32'h0000_1000, 4'hF, 1'h1, 1'h0, 1'h0, k[1]);
		end
		dev(1'h1, 3'h0, wc(8'hFF, 2'h3, 2'h3, 1'h0));
		acc(32'h0000_1000, 4'hF, 1'h1, 1'h0, 1'h1, 1'h0);
		close_out();
	end
	initial begin
		repeat (30000) @(posedge clk_i);
		err_total = err_total + 1;
		close_out();
	end
endmodule : dwa_tb
`default_nettype wire
